// ### design/uc_bus_end.sv
`timescale 1ns/10ps
// minimal microcontroller-side end: drives the multiplexed bus as commanded
module uc_bus_end
  import uc_glue_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  uc_glue_if.uc bus,
  input wire logic latchStrobe,
  input wire logic fetchN,
  input wire logic writeN,
  input wire logic readN,
  input wire logic [DATA_W-1:0] addrDataOut,
  input wire logic [ADDR_HI_W-1:0] upperAddr,
  input wire logic [7:0] portOneOut,
  input wire logic [7:0] portOneOe,
  input wire logic [7:0] portThreeOut,
  input wire logic [7:0] portThreeOe,
  output logic [7:0] portOneIn,
  output logic [7:0] portThreeIn,
  output logic inReset
);
  logic [7:0] p1In_r, p1In_nxt;
  logic [7:0] p3In_r, p3In_nxt;

  always_comb begin
    p1In_nxt = bus.gpPortOne;
    p3In_nxt = bus.specialFnPort;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      p1In_r <= '1;
      p3In_r <= '1;
    end else begin
      p1In_r <= p1In_nxt;
      p3In_r <= p3In_nxt;
    end
  end

  assign portOneIn = p1In_r;
  assign portThreeIn = p3In_r;
  assign inReset = bus.ucReset;
  // while held in reset all pins float to the weak pull-up
  assign bus.addrLatchStrobe = bus.ucReset ? 1'b1 : latchStrobe;
  assign bus.progFetchStrobeN = bus.ucReset ? 1'b1 : fetchN;
  assign bus.muxedAddrDataPort = bus.ucReset ? 8'hff : addrDataOut;
  assign bus.upperAddrPort = bus.ucReset ? 8'hff : upperAddr;
  assign bus.gpPortOneUcOut = portOneOut;
  assign bus.gpPortOneUcOe = bus.ucReset ? 8'h00 : portOneOe;
  always_comb begin
    bus.specialFnPortUcOut = portThreeOut;
    bus.specialFnPortUcOut[SF_WRITE] = writeN;
    bus.specialFnPortUcOut[7] = readN;
    bus.specialFnPortUcOe = bus.ucReset ? 8'h00 : (portThreeOe | 8'hc0);
  end
endmodule

// ### design/uc_glue_if.sv
`timescale 1ns/10ps
interface uc_glue_if;
  import uc_glue_pkg::*;
  // uc side pins
  logic ucClockIn;
  logic ucReset;
  logic addrLatchStrobe;
  logic progFetchStrobeN;
  logic [DATA_W-1:0] muxedAddrDataPort;
  logic [ADDR_HI_W-1:0] upperAddrPort;
  // port one / three: uc drives with enable, glue drives with enable
  logic [7:0] gpPortOneUcOut;
  logic [7:0] gpPortOneUcOe;
  logic [7:0] gpPortOneGlueOut;
  logic [7:0] gpPortOneGlueOe;
  logic [7:0] specialFnPortUcOut;
  logic [7:0] specialFnPortUcOe;
  logic [7:0] specialFnPortGlueOut;
  logic [7:0] specialFnPortGlueOe;
  // resolved levels, weak pull-up when nobody drives
  logic [7:0] gpPortOne;
  logic [7:0] specialFnPort;
  // sram side
  logic [ADDR_LO_W-1:0] sramAddrLo;
  logic sramAddrTop;
  logic sramChipEnN;
  logic sramOutEnN;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_res
      assign gpPortOne[i] = gpPortOneGlueOe[i] ? gpPortOneGlueOut[i] :
                            gpPortOneUcOe[i] ? gpPortOneUcOut[i] : 1'b1;
      assign specialFnPort[i] = specialFnPortGlueOe[i] ? specialFnPortGlueOut[i] :
                                specialFnPortUcOe[i] ? specialFnPortUcOut[i] : 1'b1;
    end
  endgenerate

  modport glue (
    output ucClockIn, ucReset, sramAddrLo, sramAddrTop, sramChipEnN, sramOutEnN,
    output gpPortOneGlueOut, gpPortOneGlueOe, specialFnPortGlueOut, specialFnPortGlueOe,
    input addrLatchStrobe, progFetchStrobeN, muxedAddrDataPort, upperAddrPort,
    input gpPortOne, specialFnPort
  );
  modport uc (
    input ucClockIn, ucReset, gpPortOne, specialFnPort,
    output addrLatchStrobe, progFetchStrobeN, muxedAddrDataPort, upperAddrPort,
    output gpPortOneUcOut, gpPortOneUcOe, specialFnPortUcOut, specialFnPortUcOe
  );
endinterface

// ### design/uc_glue_pkg.sv
package uc_glue_pkg;
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_W = 8;
  localparam int DATA_W = 8;
  localparam int SEG_W = 7;
  localparam int PC_DATA_W = 8;
  localparam int STATUS_W = 5;
  // uc clock divider: toggle every UC_CLK_HALF cycles of clk
  localparam int UC_CLK_HALF = 2;
  localparam logic [1:0] UC_CLK_CNT_LAST = 2'h1;
  // reset value of held-reset output
  localparam logic UC_RESET_INIT = 1'b1;
  // sram decode: ram answers when upper byte index at or below this limit
  localparam logic [ADDR_HI_W-1:0] RAM_TOP_LARGE = 8'hff;
  localparam logic [ADDR_HI_W-1:0] RAM_TOP_SMALL = 8'h7f;
  // special function pin indices on port three
  localparam int SF_INT0 = 2;
  localparam int SF_PS2_CLK = 4;
  localparam int SF_PS2_DAT = 1;
  localparam int SF_WRITE = 6;
  typedef enum logic [1:0] {SRC_NONE, SRC_UC, SRC_GLUE} status_src_t;
endpackage

// ### design/uc_sram_glue_logic.sv
`timescale 1ns/10ps
// Summary of operation
// - oscillator clocks logic, divided clock drives uc
// - uc port zero muxes low address, data
// - latch low address byte on strobe
// - uc drives upper address on port two
// - small ram seven bits, large ram eight
// - decode upper byte, strobes into enables
// - enable high disables the ram
// - glue output holds uc reset
// - uc weakly pulls pins while in reset
// - release special pin for external driver
// - glue may drive special pins, interrupts
// - drive seven segments from uc ports
// - relay host data bits to uc
// - status lines driven by uc or glue
// - keyboard clock and data on port three
module uc_sram_glue_logic
  import uc_glue_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  uc_glue_if.glue bus,
  input wire logic largeRam,
  input wire logic holdUcReset,
  input wire logic segFromPortOne,
  input wire logic [PC_DATA_W-1:0] pcData,
  input wire logic relayPcData,
  input wire logic [STATUS_W-1:0] glueStatusData,
  input wire logic glueDrivesStatus,
  input wire logic extDrivesSpecial,
  input wire logic raiseInt,
  output logic [SEG_W-1:0] segmentLines,
  output logic [STATUS_W-1:0] pcStatus,
  output logic ps2Clk,
  output logic ps2Data,
  output logic [ADDR_LO_W-1:0] latchedAddr
);
  logic [1:0] clkCnt_r, clkCnt_nxt;
  logic ucClk_r, ucClk_nxt;
  logic ucReset_r, ucReset_nxt;
  logic [ADDR_LO_W-1:0] addrHold_r, addrHold_nxt;
  logic [SEG_W-1:0] seg_r, seg_nxt;
  logic [STATUS_W-1:0] status_r, status_nxt;
  logic ps2Clk_r, ps2Clk_nxt;
  logic ps2Data_r, ps2Data_nxt;
  logic [ADDR_HI_W-1:0] ramTop;
  logic ramHit;
  logic writeStrobeN;
  logic readStrobeN;
  status_src_t statusSrc;

  // uc clock divider
  always_comb begin
    clkCnt_nxt = clkCnt_r + 2'h1;
    ucClk_nxt = ucClk_r;
    if (clkCnt_r == UC_CLK_CNT_LAST) begin
      clkCnt_nxt = 2'h0;
      ucClk_nxt = ~ucClk_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clkCnt_r <= 2'h0;
      ucClk_r <= 1'b0;
    end else begin
      clkCnt_r <= clkCnt_nxt;
      ucClk_r <= ucClk_nxt;
    end
  end

  // uc reset hold, registered so the uc pin never glitches
  always_comb begin
    ucReset_nxt = holdUcReset;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ucReset_r <= UC_RESET_INIT;
    end else begin
      ucReset_r <= ucReset_nxt;
    end
  end

  assign bus.ucClockIn = ucClk_r;
  assign bus.ucReset = ucReset_r;

  // low address latch, transparent while strobe high
  always_comb begin
    addrHold_nxt = addrHold_r;
    if (bus.addrLatchStrobe) begin
      addrHold_nxt = bus.muxedAddrDataPort;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addrHold_r <= '0;
    end else begin
      addrHold_r <= addrHold_nxt;
    end
  end

  assign latchedAddr = bus.addrLatchStrobe ? bus.muxedAddrDataPort : addrHold_r;
  assign bus.sramAddrLo = latchedAddr;
  assign bus.sramAddrTop = largeRam & bus.upperAddrPort[ADDR_HI_W-1];

  // sram enable decode
  assign writeStrobeN = bus.specialFnPort[SF_WRITE];
  assign readStrobeN = bus.specialFnPort[7];
  assign ramTop = largeRam ? RAM_TOP_LARGE : RAM_TOP_SMALL;
  assign ramHit = (bus.upperAddrPort <= ramTop) && !ucReset_r;
  // ram stays off while the uc is held so the glue owns the shared pins
  always_comb begin
    bus.sramChipEnN = 1'b1;
    bus.sramOutEnN = 1'b1;
    if (ramHit && (!bus.progFetchStrobeN || !writeStrobeN || !readStrobeN)) begin
      bus.sramChipEnN = 1'b0;
      // no output drive on writes, the uc owns port zero then
      if (writeStrobeN) begin
        bus.sramOutEnN = 1'b0;
      end
    end
  end

  // display segments follow the chosen uc port
  always_comb begin
    seg_nxt = segFromPortOne ? bus.gpPortOne[SEG_W-1:0] :
              bus.specialFnPort[SEG_W-1:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seg_r <= '0;
    end else begin
      seg_r <= seg_nxt;
    end
  end

  // host status: glue data while glue owns the lines, else the uc pins
  always_comb begin
    statusSrc = glueDrivesStatus ? SRC_GLUE : SRC_UC;
    case (statusSrc)
      SRC_GLUE: status_nxt = glueStatusData;
      default: status_nxt = {bus.specialFnPort[SF_PS2_DAT], bus.gpPortOne[6:4],
                             bus.gpPortOne[0]};
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // keyboard lines share port three pins with the uc
  always_comb begin
    ps2Clk_nxt = bus.specialFnPort[SF_PS2_CLK];
    ps2Data_nxt = bus.specialFnPort[SF_PS2_DAT];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ps2Clk_r <= 1'b1;
      ps2Data_r <= 1'b1;
    end else begin
      ps2Clk_r <= ps2Clk_nxt;
      ps2Data_r <= ps2Data_nxt;
    end
  end

  assign segmentLines = seg_r;
  assign pcStatus = status_r;
  assign ps2Clk = ps2Clk_r;
  assign ps2Data = ps2Data_r;

  // port one: relay host data on bits 3:0 when asked, status pins 6:4 and 0 when glue owns status
  always_comb begin
    bus.gpPortOneGlueOut = pcData;
    bus.gpPortOneGlueOe = '0;
    if (relayPcData) begin
      bus.gpPortOneGlueOe = 8'h0f;
    end
    if (glueDrivesStatus) begin
      bus.gpPortOneGlueOut[6:4] = glueStatusData[3:1];
      bus.gpPortOneGlueOut[0] = glueStatusData[0];
      bus.gpPortOneGlueOe[6:4] = 3'h7;
      bus.gpPortOneGlueOe[0] = 1'b1;
    end
  end

  // port three: interrupt line and status bit, released for external drivers
  always_comb begin
    bus.specialFnPortGlueOut = '1;
    bus.specialFnPortGlueOe = '0;
    bus.specialFnPortGlueOut[SF_INT0] = ~raiseInt;
    bus.specialFnPortGlueOe[SF_INT0] = !extDrivesSpecial;
    if (glueDrivesStatus && !extDrivesSpecial) begin
      bus.specialFnPortGlueOut[SF_PS2_DAT] = glueStatusData[4];
      bus.specialFnPortGlueOe[SF_PS2_DAT] = 1'b1;
    end
  end
endmodule

// ### test/uc_glue_asserts.sv
`timescale 1ns/10ps
module uc_glue_asserts
  import uc_glue_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ucClockIn,
  input wire logic ucReset,
  input wire logic addrLatchStrobe,
  input wire logic progFetchStrobeN,
  input wire logic [DATA_W-1:0] muxedAddrDataPort,
  input wire logic [ADDR_HI_W-1:0] upperAddrPort,
  input wire logic [7:0] specialFnPort,
  input wire logic [ADDR_LO_W-1:0] sramAddrLo,
  input wire logic sramAddrTop,
  input wire logic sramChipEnN,
  input wire logic sramOutEnN,
  input wire logic extDrivesSpecial,
  input wire logic [7:0] gpPortOneGlueOe,
  input wire logic [7:0] gpPortOneUcOe,
  input wire logic [7:0] specialFnPortGlueOe,
  input wire logic [7:0] specialFnPortUcOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_UC_HELD: assert property ($fell(reset) |-> ucReset)
    else $error("uc reset not held");
  AST_LATCH_PASS: assert property (addrLatchStrobe |-> sramAddrLo == muxedAddrDataPort)
    else $error("latch not transparent");
  AST_LATCH_HOLD: assert property (!addrLatchStrobe && !$fell(reset) |-> $stable(sramAddrLo))
    else $error("latch lost value");
  AST_RAM_OFF: assert property (ucReset |-> sramChipEnN && sramOutEnN)
    else $error("ram enabled in uc reset");
  AST_WRITE_NO_OE: assert property (!specialFnPort[SF_WRITE] |-> sramOutEnN)
    else $error("output enable during write");
  AST_FETCH_ON: assert property (!ucReset && !progFetchStrobeN && specialFnPort[SF_WRITE]
    && upperAddrPort <= RAM_TOP_SMALL |-> !sramChipEnN && !sramOutEnN)
    else $error("fetch not enabling ram");
  AST_UC_CLK: assert property ($changed(ucClockIn) |=> $stable(ucClockIn) ##1 $changed(ucClockIn))
    else $error("uc clock period wrong");
  AST_TOP_BIT: assert property (sramAddrTop |-> upperAddrPort[7])
    else $error("top address without bit");
  AST_ONE_DRIVER: assert property ((gpPortOneGlueOe & gpPortOneUcOe & 8'h71) == 8'h00
    && (specialFnPortGlueOe & specialFnPortUcOe & 8'h02) == 8'h00)
    else $error("status line driven twice");
  AST_EXT_FREE: assert property (extDrivesSpecial |-> !specialFnPortGlueOe[SF_INT0])
    else $error("special pin not released");
endmodule

// ### test/uc_sram_glue_logic_tb_top.sv
`timescale 1ns/10ps
module uc_sram_glue_logic_tb_top
  import uc_glue_pkg::*;
;
  logic clk, reset, largeRam, holdUcReset, segFromPortOne, relayPcData, glueDrivesStatus;
  logic extDrivesSpecial, raiseInt, latchStrobe, fetchN, writeN, readN, ps2Clk, ps2Data, inReset;
  logic [7:0] pcData, addrDataOut, upperAddr, portOneOut, portOneOe, portThreeOut, portThreeOe;
  logic [7:0] latchedAddr, portOneIn, portThreeIn;
  logic [STATUS_W-1:0] glueStatusData, pcStatus;
  logic [SEG_W-1:0] segmentLines;
  int error_cnt, tests_run;
  uc_glue_if bus ();
  uc_sram_glue_logic uc_sram_glue_logic_inst (.clk(clk), .reset(reset), .bus(bus),
    .largeRam(largeRam), .holdUcReset(holdUcReset), .segFromPortOne(segFromPortOne),
    .pcData(pcData), .relayPcData(relayPcData), .glueStatusData(glueStatusData),
    .glueDrivesStatus(glueDrivesStatus), .extDrivesSpecial(extDrivesSpecial),
    .raiseInt(raiseInt), .segmentLines(segmentLines), .pcStatus(pcStatus), .ps2Clk(ps2Clk),
    .ps2Data(ps2Data), .latchedAddr(latchedAddr));
  uc_bus_end uc_bus_end_inst (.clk(clk), .reset(reset), .bus(bus), .latchStrobe(latchStrobe),
    .fetchN(fetchN), .writeN(writeN), .readN(readN), .addrDataOut(addrDataOut),
    .upperAddr(upperAddr), .portOneOut(portOneOut), .portOneOe(portOneOe),
    .portThreeOut(portThreeOut), .portThreeOe(portThreeOe), .portOneIn(portOneIn),
    .portThreeIn(portThreeIn), .inReset(inReset));
  uc_glue_asserts uc_glue_asserts_inst (.clk(clk), .reset(reset), .ucClockIn(bus.ucClockIn),
    .ucReset(bus.ucReset), .addrLatchStrobe(bus.addrLatchStrobe),
    .progFetchStrobeN(bus.progFetchStrobeN), .muxedAddrDataPort(bus.muxedAddrDataPort),
    .upperAddrPort(bus.upperAddrPort), .specialFnPort(bus.specialFnPort),
    .sramAddrLo(bus.sramAddrLo), .sramAddrTop(bus.sramAddrTop),
    .sramChipEnN(bus.sramChipEnN), .sramOutEnN(bus.sramOutEnN),
    .extDrivesSpecial(extDrivesSpecial), .gpPortOneGlueOe(bus.gpPortOneGlueOe),
    .gpPortOneUcOe(bus.gpPortOneUcOe), .specialFnPortGlueOe(bus.specialFnPortGlueOe),
    .specialFnPortUcOe(bus.specialFnPortUcOe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset;
    chk(bus.ucReset, 8'h01);
    chk(bus.ucClockIn, 8'h00);
    reset = 1'b0;
    ticks(3);
    chk({bus.ucReset, bus.sramChipEnN, bus.sramOutEnN}, 8'h07);
    holdUcReset = 1'b0;
    ticks(2);
    chk({bus.ucReset, inReset}, 8'h00);
  endtask
  task automatic t_latch;
    latchStrobe = 1'b1;
    addrDataOut = 8'ha5;
    #1 chk(bus.sramAddrLo, 8'ha5);
    ticks(1);
    latchStrobe = 1'b0;
    addrDataOut = 8'h3c;
    ticks(1);
    chk(bus.sramAddrLo, 8'ha5);
    chk(latchedAddr, 8'ha5);
  endtask
  task automatic t_decode;
    logic [11:0] tv [5] = '{12'h312, 12'h512, 12'h612, 12'h380, 12'hb80};
    logic [2:0] ex [5] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h4};
    for (int i = 0; i < 5; i++) begin
      {largeRam, fetchN, writeN, readN, upperAddr} = tv[i];
      #1 chk({bus.sramAddrTop, bus.sramChipEnN, bus.sramOutEnN}, ex[i]);
      ticks(1);
    end
    {largeRam, fetchN, writeN, readN} = 4'h7;
  endtask
  task automatic t_clkdiv;
    logic [7:0] v;
    v = 8'h00;
    repeat (8) begin
      @(posedge clk);
      #1 v = {v[6:0], bus.ucClockIn};
    end
    chk(v[5:0] ^ v[7:2], 8'h3f);
    ticks(1);
  endtask
  task automatic t_side;
    segFromPortOne = 1'b1;
    portOneOe = 8'h7f;
    portOneOut = 8'h55;
    ticks(3);
    chk(segmentLines, 8'h55);
    segFromPortOne = 1'b0;
    portOneOe = 8'h00;
    portThreeOe = 8'h3f;
    portThreeOut = 8'h24;
    ticks(3);
    chk(segmentLines, 8'h64);
    chk({ps2Clk, ps2Data}, 8'h00);
    relayPcData = 1'b1;
    pcData = 8'h0a;
    portThreeOe = 8'h00;
    ticks(3);
    chk(portOneIn[3:0], 8'h0a);
    relayPcData = 1'b0;
    glueDrivesStatus = 1'b1;
    glueStatusData = 5'h15;
    ticks(3);
    chk(pcStatus, 8'h15);
    chk({portOneIn[6:4], portOneIn[0]}, 8'h05);
    glueDrivesStatus = 1'b0;
    raiseInt = 1'b1;
    ticks(3);
    chk(portThreeIn[SF_INT0], 8'h00);
    extDrivesSpecial = 1'b1;
    ticks(3);
    chk({bus.specialFnPortGlueOe[SF_INT0], portThreeIn[SF_INT0]}, 8'h01);
  endtask
  task automatic t_status_uc;
    portOneOe = 8'h71;
    portOneOut = 8'h50;
    portThreeOe = 8'h02;
    portThreeOut = 8'h02;
    ticks(3);
    chk(pcStatus, 8'h1a);
    chk(bus.gpPortOneGlueOe & 8'h71, 8'h00);
    chk({ps2Clk, ps2Data}, 8'h03);
  endtask
  initial begin
    {largeRam, segFromPortOne, relayPcData, glueDrivesStatus, extDrivesSpecial} = 5'h00;
    {raiseInt, latchStrobe, portOneOe, portThreeOe, addrDataOut, upperAddr} = 34'h0;
    {pcData, glueStatusData, portOneOut} = 21'h0;
    {holdUcReset, fetchN, writeN, readN} = 4'hf;
    portThreeOut = 8'hff;
    error_cnt = 0;
    tests_run = 0;
    reset = 1'b1;
    ticks(5);
    t_reset();
    t_latch();
    t_decode();
    t_clkdiv();
    t_side();
    t_status_uc();
    final_report();
  end
  initial begin
    #2000;
    error_cnt++;
    final_report();
  end
endmodule
